/* rtl/access_control_services_regs.sv */
// Access control services capability register bank of one switch port.
// Assumes an APB master on pclk and straps that are steady across reset.
//
// Functional notes
// - Header bits 15:0 always read 0x000d; writes do not change them.
// - Header bits 19:16 always read version 0x1.
// - Header bits 31:20 hold a lockable next pointer; zero ends the list.
// - Capability bits 6:0 read zero upstream; lockable, reset all ones downstream.
// - Capability bits 15:8 read zero upstream; lockable, reset 0x10 downstream.
// - Enable bits 0 and 1 reset zero; zero upstream, writable downstream.
// - Downstream enable bits stay writable even with capability bits cleared.
// - Enable bits 2 and 3 are redirect enables; zero upstream.
// - Enable bit 4 turns on upstream forwarding downstream; zero upstream.
// - Enable bit 5 turns on egress control downstream; upstream ignores writes.
// - Enable bit 6 is direct translated control; bits 15:7 read zero.
// - With egress control on, set vector bits block targets; own bit reads zero.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps

module access_control_services_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port straps
  input wire logic upstream_strap,
  input wire logic [3:0] port_number_strap,
  // Forwarding controls
  output acs_pkg::acs_enable_type port_enables,
  output logic [15:0] egress_block_mask
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  logic strap_taken;
  logic upstream_port;
  logic [3:0] own_port;
  logic locked;
  logic [11:0] next_pointer;
  logic [6:0] capability_bits;
  logic [7:0] egress_size;
  logic [6:0] enable_bits;
  logic [15:0] egress_vector_bits;
  logic [15:0] vector_view;
  logic [31:0] next_prdata;
  logic [31:0] merged;
  logic next_pslverr;
  logic setup_phase;
  logic write_edge;
  logic hit_header;
  logic hit_capability;
  logic hit_enables;
  logic hit_egress;
  logic hit_lock;
  logic downstream;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0] strobes);
    logic [31:0] result;
    result = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strobes[i]) begin
        result[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return result;
  endfunction : merge_bytes

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. The slave never stalls, so every transfer ends after one setup and one access cycle.
  assign pready = 1'b1;
  assign setup_phase = psel & ~penable;
  assign write_edge = psel & penable & pwrite;
  assign hit_header = (paddr[11:2] == acs_pkg::HEADER_ADDR[11:2]);
  assign hit_capability = (paddr[11:2] == acs_pkg::CAPABILITY_ADDR[11:2]);
  assign hit_enables = (paddr[11:2] == acs_pkg::ENABLES_ADDR[11:2]);
  assign hit_egress = (paddr[11:2] == acs_pkg::EGRESS_ADDR[11:2]);
  assign hit_lock = (paddr[11:2] == acs_pkg::LOCK_ADDR[11:2]);
  assign downstream = strap_taken & ~upstream_port;
  assign merged = merge_bytes(next_prdata, pwdata, pstrb);

  ////////////////////////////////////////////////////////////////////////////
  // Straps are sampled on the first edge after reset is released.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_taken <= 1'b0;
      upstream_port <= 1'b1;
      own_port <= 4'h0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      upstream_port <= upstream_strap;
      own_port <= port_number_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock. Once set it holds until reset, so boot code can freeze the fields.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked <= 1'b0;
    end else if (write_edge && hit_lock && merged[acs_pkg::LOCK_BIT]) begin
      locked <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Header pointer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_pointer <= acs_pkg::NEXT_POINTER_RESET;
    end else if (write_edge && hit_header && !locked) begin
      next_pointer <= merged[31:acs_pkg::POINTER_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capability fields. Written only on a downstream port, and read as zero on an upstream port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capability_bits <= acs_pkg::CAPABILITY_BITS_RESET;
      egress_size <= acs_pkg::EGRESS_SIZE_RESET;
    end else if (write_edge && hit_capability && !locked && downstream) begin
      capability_bits <= merged[6:0];
      egress_size <= merged[acs_pkg::SIZE_LSB +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enables. Not gated by capability bits, which software may clear freely.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_bits <= acs_pkg::ENABLES_RESET;
    end else if (write_edge && hit_enables && downstream) begin
      enable_bits <= merged[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Egress vector. The bit of this port's own number is never stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      egress_vector_bits <= acs_pkg::EGRESS_VECTOR_RESET;
    end else if (write_edge && hit_egress) begin
      egress_vector_bits <= merged[15:0] & vector_view;
    end
  end

  generate
    for (genvar g = 0; g < 16; g++) begin : g_own_bit
      assign vector_view[g] = (own_port != 4'(g));
      assign egress_block_mask[g] = egress_vector_bits[g] & vector_view[g]
                                    & port_enables.egress_control;
    end
  endgenerate

  assign port_enables = downstream ? enable_bits : 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux. Read data is built in the setup cycle and held by a flop.
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (hit_header) begin
      next_prdata = {next_pointer, acs_pkg::STRUCTURE_VERSION,
                     acs_pkg::STRUCTURE_IDENTIFIER};
    end else if (hit_capability) begin
      if (downstream) begin
        next_prdata[15:0] = {egress_size, 1'b0, capability_bits};
      end
    end else if (hit_enables) begin
      next_prdata[6:0] = port_enables;
    end else if (hit_egress) begin
      next_prdata[15:0] = egress_vector_bits & vector_view;
    end else if (hit_lock) begin
      next_prdata[acs_pkg::LOCK_BIT] = locked;
    end else begin
      next_pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_header_id;
    @(posedge pclk) disable iff (!presetn)
      setup_phase && !pwrite && hit_header |=>
        prdata[15:0] == acs_pkg::STRUCTURE_IDENTIFIER;
  endproperty
  a_header_id: assert property (p_header_id)
    else $error("Header identifier read wrong.");

  property p_header_version;
    @(posedge pclk) disable iff (!presetn)
      setup_phase && !pwrite && hit_header |=>
        prdata[19:16] == acs_pkg::STRUCTURE_VERSION;
  endproperty
  a_header_version: assert property (p_header_version)
    else $error("Header version read wrong.");

  property p_pointer_locked;
    @(posedge pclk) disable iff (!presetn)
      write_edge && hit_header && locked |=> $stable(next_pointer);
  endproperty
  a_pointer_locked: assert property (p_pointer_locked)
    else $error("Locked pointer changed.");

  property p_cap_upstream;
    @(posedge pclk) disable iff (!presetn)
      setup_phase && !pwrite && hit_capability && upstream_port |=>
        prdata == 32'h0000_0000;
  endproperty
  a_cap_upstream: assert property (p_cap_upstream)
    else $error("Upstream capability not zero.");

  property p_size_write;
    @(posedge pclk) disable iff (!presetn)
      write_edge && hit_capability && downstream && !locked && pstrb[1] |=>
        egress_size == $past(pwdata[15:8]);
  endproperty
  a_size_write: assert property (p_size_write)
    else $error("Vector size not written.");

  property p_enables_upstream;
    @(posedge pclk) disable iff (!presetn)
      strap_taken && upstream_port |-> port_enables == 7'h00;
  endproperty
  a_enables_upstream: assert property (p_enables_upstream)
    else $error("Upstream enables not zero.");

  property p_enable_write;
    @(posedge pclk) disable iff (!presetn)
      write_edge && hit_enables && downstream && pstrb[0] |=>
        port_enables == $past(pwdata[6:0]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("Enable write lost.");

  property p_enable_reserved;
    @(posedge pclk) disable iff (!presetn)
      setup_phase && !pwrite && hit_enables |=> prdata[31:7] == 25'h0;
  endproperty
  a_enable_reserved: assert property (p_enable_reserved)
    else $error("Reserved enable bits not zero.");

  property p_own_bit;
    @(posedge pclk) disable iff (!presetn)
      strap_taken |-> egress_block_mask[own_port] == 1'b0
        && (port_enables.egress_control || egress_block_mask == 16'h0000);
  endproperty
  a_own_bit: assert property (p_own_bit)
    else $error("Egress mask wrong.");

  property p_lock_holds;
    @(posedge pclk) disable iff (!presetn)
      locked |=> locked && $stable(capability_bits) && $stable(egress_size);
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("Locked fields changed.");

  // Bus side checks: reserved bits, dropped writes and error answers.
  // A partial strobe must leave the unstrobed bytes of a field alone.
  property p_cap_reserved;
    @(posedge pclk) disable iff (!presetn)
      setup_phase && !pwrite && hit_capability |=>
        prdata[31:16] == 16'h0000 && prdata[7] == 1'b0;
  endproperty
  a_cap_reserved: assert property (p_cap_reserved)
    else $error("Capability reserved bits not zero.");

  property p_cap_bits_write;
    @(posedge pclk) disable iff (!presetn)
      write_edge && hit_capability && downstream && !locked && pstrb[0] |=>
        capability_bits == $past(pwdata[6:0]);
  endproperty
  a_cap_bits_write: assert property (p_cap_bits_write)
    else $error("Capability bits not written.");

  property p_pointer_write;
    @(posedge pclk) disable iff (!presetn)
      write_edge && hit_header && !locked && pstrb[3] && pstrb[2] |=>
        next_pointer == $past(pwdata[31:20]);
  endproperty
  a_pointer_write: assert property (p_pointer_write)
    else $error("Next pointer not written.");

  property p_enables_upstream_write;
    @(posedge pclk) disable iff (!presetn)
      write_edge && hit_enables && !downstream |=> $stable(enable_bits);
  endproperty
  a_enables_upstream_write: assert property (p_enables_upstream_write)
    else $error("Upstream enable write not ignored.");

  property p_write_reads_zero;
    @(posedge pclk) disable iff (!presetn)
      setup_phase && pwrite |=> prdata == 32'h0000_0000;
  endproperty
  a_write_reads_zero: assert property (p_write_reads_zero)
    else $error("Read data not zero on a write.");

  property p_unmapped_error;
    @(posedge pclk) disable iff (!presetn)
      setup_phase && !(hit_header || hit_capability || hit_enables || hit_egress
        || hit_lock) |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped_error: assert property (p_unmapped_error)
    else $error("Unmapped access not refused.");

  property p_vector_own;
    @(posedge pclk) disable iff (!presetn)
      strap_taken && write_edge && hit_egress |=> egress_vector_bits[own_port] == 1'b0;
  endproperty
  a_vector_own: assert property (p_vector_own)
    else $error("Own vector bit stored.");

  c_read_header: cover property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !pwrite && hit_header);
  c_egress_block: cover property (@(posedge pclk) disable iff (!presetn)
    egress_block_mask != 16'h0000);
  c_locked_write: cover property (@(posedge pclk) disable iff (!presetn)
    write_edge && hit_capability && locked);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr && penable);
  c_partial_write: cover property (@(posedge pclk) disable iff (!presetn)
    write_edge && pstrb != 4'hf);

endmodule : access_control_services_regs

/* rtl/acs_pkg.sv */
// Constants and types for the access control services register bank.
// Assumes an APB slave with 12-bit byte addresses and one register per word.
package acs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices. The byte address is four times the index.
  localparam logic [11:0] HEADER_INDEX = 12'h320;
  localparam logic [11:0] CAPABILITY_INDEX = 12'h324;
  localparam logic [11:0] ENABLES_INDEX = 12'h326;
  localparam logic [11:0] EGRESS_INDEX = 12'h328;
  localparam logic [11:0] LOCK_INDEX = 12'h32a;
  localparam logic [11:0] HEADER_ADDR = {HEADER_INDEX[9:0], 2'b00};
  localparam logic [11:0] CAPABILITY_ADDR = {CAPABILITY_INDEX[9:0], 2'b00};
  localparam logic [11:0] ENABLES_ADDR = {ENABLES_INDEX[9:0], 2'b00};
  localparam logic [11:0] EGRESS_ADDR = {EGRESS_INDEX[9:0], 2'b00};
  localparam logic [11:0] LOCK_ADDR = {LOCK_INDEX[9:0], 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int VERSION_LSB = 16;
  localparam int POINTER_LSB = 20;
  localparam int SIZE_LSB = 8;
  localparam int EGRESS_ENABLE_BIT = 5;
  localparam int LOCK_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed and reset values.
  localparam logic [15:0] STRUCTURE_IDENTIFIER = 16'h000d;
  localparam logic [3:0] STRUCTURE_VERSION = 4'h1;
  localparam logic [11:0] NEXT_POINTER_RESET = 12'h000;
  localparam logic [6:0] CAPABILITY_BITS_RESET = 7'h7f;
  localparam logic [7:0] EGRESS_SIZE_RESET = 8'h10;
  localparam logic [6:0] ENABLES_RESET = 7'h00;
  localparam logic [15:0] EGRESS_VECTOR_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Per-function enables handed to the forwarding logic, bit 6 first.
  typedef struct packed {
    logic direct_translated;
    logic egress_control;
    logic upstream_forwarding;
    logic completion_redirect;
    logic request_redirect;
    logic translation_blocking;
    logic source_validation;
  } acs_enable_type;

endpackage : acs_pkg

/* verification/access_control_services_regs_tb_top.sv */
// Self-checking bench for the access control services register bank.
// Assumes an APB slave on pclk and straps sampled just after reset.
`timescale 1ns/1ps

module access_control_services_regs_tb_top;

  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic upstream_strap;
  logic [3:0] port_number_strap;
  acs_pkg::acs_enable_type port_enables;
  logic [15:0] egress_block_mask;
  int mismatches;
  int checked;
  logic [31:0] rdata;
  logic rerr;

  ////////////////////////////////////////////////////////////////////////////
  access_control_services_regs access_control_services_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .upstream_strap(upstream_strap), .port_number_strap(port_number_strap),
    .port_enables(port_enables), .egress_block_mask(egress_block_mask)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic compare_word(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : compare_word

  task automatic compare_flag(input string name, input logic exp, input logic seen);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %b seen %b", name, exp, seen);
    end
  endtask : compare_flag

  task automatic stop_test;
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // Each transfer opens on its own edge, so back to back calls never drive psel twice at once.
  task automatic apb_access(input logic write, input logic [11:0] addr, input logic [31:0] data,
                            input logic [3:0] strb);
    int waited;
    waited = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= write;
    paddr <= addr;
    pwdata <= data;
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && waited < 100) begin
      waited++;
      @(posedge pclk);
    end
    if (waited >= 100) begin
      mismatches++;
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_access

  task automatic reg_write(input logic [11:0] addr, input logic [31:0] data);
    apb_access(1'b1, addr, data, 4'hf);
  endtask : reg_write

  task automatic reg_write_bytes(input logic [11:0] addr, input logic [31:0] data,
                                 input logic [3:0] strb);
    apb_access(1'b1, addr, data, strb);
  endtask : reg_write_bytes

  task automatic reg_read(input logic [11:0] addr);
    apb_access(1'b0, addr, 32'h0000_0000, 4'h0);
  endtask : reg_read

  // Two edges let any output register behind the bank land before it is looked at.
  task automatic settle;
    repeat (2) @(posedge pclk);
  endtask : settle

  task automatic apply_reset(input logic upstream);
    presetn <= 1'b0;
    upstream_strap <= upstream;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : apply_reset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mismatches = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    upstream_strap = 1'b0;
    port_number_strap = 4'h3;
    apply_reset(1'b0);
    reg_read(acs_pkg::HEADER_ADDR);
    compare_word("header", 32'h0001_000d, rdata);
    reg_read(acs_pkg::CAPABILITY_ADDR);
    compare_word("capability", 32'h0000_107f, rdata);
    reg_read(acs_pkg::ENABLES_ADDR);
    compare_word("enables", 32'h0000_0000, rdata);
    compare_flag("pslverr", 1'b0, rerr);
    reg_write(acs_pkg::HEADER_ADDR, 32'h5a5f_ffff);
    reg_read(acs_pkg::HEADER_ADDR);
    compare_word("header", 32'h5a51_000d, rdata);
    reg_write_bytes(acs_pkg::CAPABILITY_ADDR, 32'hffff_08ff, 4'h2);
    reg_read(acs_pkg::CAPABILITY_ADDR);
    compare_word("capability", 32'h0000_087f, rdata);
    reg_write(acs_pkg::CAPABILITY_ADDR, 32'h0000_0000);
    reg_read(acs_pkg::CAPABILITY_ADDR);
    compare_word("capability", 32'h0000_0000, rdata & 32'h0000_00ff);
    for (int i = 0; i < 7; i++) begin
      reg_write(acs_pkg::ENABLES_ADDR, 32'h1 << i);
      reg_read(acs_pkg::ENABLES_ADDR);
      compare_word("enables", 32'h1 << i, rdata);
      settle();
      compare_word("port_enables", 32'h1 << i, {25'h0, port_enables});
    end
    reg_write(acs_pkg::ENABLES_ADDR, 32'hffff_ffff);
    reg_read(acs_pkg::ENABLES_ADDR);
    compare_word("enables", 32'h0000_007f, rdata);
    reg_write(acs_pkg::EGRESS_ADDR, 32'h0000_ffff);
    reg_read(acs_pkg::EGRESS_ADDR);
    compare_word("egress vector", 32'h0000_fff7, rdata);
    settle();
    compare_word("egress mask", 32'h0000_fff7, {16'h0, egress_block_mask});
    reg_write(acs_pkg::ENABLES_ADDR, 32'h0000_001f);
    settle();
    compare_word("egress mask", 32'h0000_0000, {16'h0, egress_block_mask});
    reg_write(acs_pkg::LOCK_ADDR, 32'h0000_0001);
    reg_write(acs_pkg::HEADER_ADDR, 32'h1230_0000);
    reg_read(acs_pkg::HEADER_ADDR);
    compare_word("header", 32'h5a51_000d, rdata);
    reg_write(acs_pkg::CAPABILITY_ADDR, 32'h0000_ffff);
    reg_read(acs_pkg::CAPABILITY_ADDR);
    compare_word("capability", 32'h0000_0000, rdata);
    reg_write(acs_pkg::ENABLES_ADDR, 32'h0000_0020);
    reg_read(acs_pkg::ENABLES_ADDR);
    compare_word("enables", 32'h0000_0020, rdata);
    reg_read(12'h004);
    compare_flag("pslverr", 1'b1, rerr);
    compare_word("unmapped", 32'h0000_0000, rdata);
    reg_write(12'h004, 32'hffff_ffff);
    compare_flag("pslverr", 1'b1, rerr);
    port_number_strap <= 4'h0;
    apply_reset(1'b1);
    reg_read(acs_pkg::HEADER_ADDR);
    compare_word("header", 32'h0001_000d, rdata);
    reg_read(acs_pkg::CAPABILITY_ADDR);
    compare_word("capability", 32'h0000_0000, rdata);
    reg_write(acs_pkg::ENABLES_ADDR, 32'h0000_007f);
    reg_read(acs_pkg::ENABLES_ADDR);
    compare_word("enables", 32'h0000_0000, rdata);
    settle();
    compare_word("port_enables", 32'h0000_0000, {25'h0, port_enables});
    reg_write(acs_pkg::EGRESS_ADDR, 32'h0000_ffff);
    reg_read(acs_pkg::EGRESS_ADDR);
    compare_word("egress vector", 32'h0000_fffe, rdata);
    settle();
    compare_word("egress mask", 32'h0000_0000, {16'h0, egress_block_mask});
    stop_test();
  end

  // The tests take well under a thousand transfers; this span only cuts a hang short.
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    stop_test();
  end

endmodule : access_control_services_regs_tb_top
